// File: hdl/spaud_core.sv
// Audio mode of the synchronous serial port: master clock generation and
// slave framing on the external bit clock, with frame transfer to the user.
// Assumes control words come from logic on sys_clk and the link pins from a codec.
module spaud_core (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control words
   input wire logic [15:0] controlOneHigh,
   input wire logic [15:0] controlOneLow,
   // Transmit frames
   input wire spaud_pkg::spaud_frame_t txFrame,
   input wire logic txValid,
   output logic txReady,
   // Received frames
   output spaud_pkg::spaud_frame_t rxFrame,
   output logic rxValid,
   output logic slaveLocked,
   // Link pins
   input wire logic bitClockPin,
   output logic bitClockOut,
   output logic bitClockOe,
   input wire logic leftRightClockIn,
   output logic leftRightClockOut,
   output logic leftRightClockOe,
   input wire logic serialDataInPin,
   output logic serialDataOutPin
);

   localparam int FW = $bits(spaud_pkg::spaud_frame_t);

   logic audioOn;
   logic masterEn;
   logic slaveEn;
   logic dataInDis;
   spaud_pkg::spaud_frame_t txHold;
   logic txFull;
   logic [1:0] sdiSync;
   logic [3:0] divCnt;
   logic halfTick;
   logic started;
   logic [4:0] bitCnt;
   logic [4:0] rxCnt;
   logic [FW-1:0] txShift;
   logic [FW-1:0] rxShift;
   logic sdoSys;
   logic slaveSel;
   logic takeM;
   logic xTxReady;
   logic xRxValid;
   logic [FW-1:0] xRxData;
   logic [1:0] lockSync;
   logic [1:0] enLink;
   logic lrcPrev;
   logic lrcEdge;
   logic synced;
   logic [FW-1:0] lTxShift;
   logic [FW-1:0] lRxShift;
   logic sdoLink;
   logic [1:0] disLink;
   logic lPendValid;
   logic [FW-1:0] lPendData;
   logic lRxPush;
   logic [FW-1:0] lRxWord;

   // ----------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------
   assign audioOn = controlOneHigh[spaud_pkg::CTRL_H_AUDIO_EN]
                    && controlOneLow[spaud_pkg::CTRL_L_PORT_EN];
   assign masterEn = audioOn && controlOneLow[spaud_pkg::CTRL_L_MASTER];
   assign slaveEn = audioOn && !controlOneLow[spaud_pkg::CTRL_L_MASTER];
   assign dataInDis = controlOneLow[spaud_pkg::CTRL_L_DATA_IN_DIS];
   assign halfTick = masterEn && (divCnt == spaud_pkg::BCLK_HALF_CYC - 4'h1);
   assign takeM = halfTick && bitClockOut && (!started || bitCnt == spaud_pkg::LAST_BIT);

   // ----------------------------------------------------------------------
   // Transmit holding word
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txFull <= 1'b0;
         txReady <= 1'b1;
         txHold <= '0;
      end else if (txValid && !txFull) begin
         txFull <= 1'b1;
         txReady <= 1'b0;
         txHold <= txFrame;
      end else if (takeM || (slaveEn && xTxReady)) begin
         txFull <= 1'b0;
         txReady <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sdiSync <= 2'h0;
      end else begin
         sdiSync <= {sdiSync[0], serialDataInPin};
      end
   end

   // ----------------------------------------------------------------------
   // Master clock generation
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         divCnt <= 4'h0;
         bitClockOut <= 1'b0;
         bitClockOe <= 1'b0;
      end else if (!masterEn) begin
         divCnt <= 4'h0;
         bitClockOut <= 1'b0;
         bitClockOe <= 1'b0;
      end else if (halfTick) begin
         divCnt <= 4'h0;
         bitClockOut <= ~bitClockOut;
         bitClockOe <= 1'b1;
      end else begin
         divCnt <= divCnt + 4'h1;
         bitClockOe <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Master framing and transmit shift on the falling bit clock
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         started <= 1'b0;
         bitCnt <= 5'h0;
         leftRightClockOut <= 1'b1;
         leftRightClockOe <= 1'b0;
         txShift <= '0;
         sdoSys <= 1'b0;
      end else if (!masterEn) begin
         started <= 1'b0;
         bitCnt <= 5'h0;
         leftRightClockOut <= 1'b1;
         leftRightClockOe <= 1'b0;
         sdoSys <= 1'b0;
      end else begin
         leftRightClockOe <= 1'b1;
         if (takeM) begin
            started <= 1'b1;
            bitCnt <= 5'h0;
            leftRightClockOut <= 1'b0;
            txShift <= txFull ? {txHold[FW-2:0], 1'b0} : '0;
            sdoSys <= txFull ? txHold[FW-1] : 1'b0;
         end else if (halfTick && bitClockOut) begin
            bitCnt <= bitCnt + 5'h1;
            if (bitCnt + 5'h1 == spaud_pkg::RIGHT_START) begin
               leftRightClockOut <= 1'b1;
            end
            sdoSys <= txShift[FW-1];
            txShift <= {txShift[FW-2:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Master receive on the rising bit clock
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxCnt <= 5'h0;
         rxShift <= '0;
      end else if (!masterEn || !started) begin
         rxCnt <= 5'h0;
      end else if (halfTick && !bitClockOut) begin
         rxCnt <= rxCnt + 5'h1;
         rxShift <= {rxShift[FW-2:0], sdiSync[1]};
      end
   end

   // ----------------------------------------------------------------------
   // Received frame out, from either mode
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxFrame <= '0;
         rxValid <= 1'b0;
      end else if (masterEn && started && halfTick && !bitClockOut
                   && rxCnt == spaud_pkg::LAST_BIT && !dataInDis) begin
         rxFrame <= {rxShift[FW-2:0], sdiSync[1]};
         rxValid <= 1'b1;
      end else if (xRxValid) begin
         rxFrame <= xRxData;
         rxValid <= 1'b1;
      end else begin
         rxValid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         slaveSel <= 1'b0;
         lockSync <= 2'h0;
         slaveLocked <= 1'b0;
      end else begin
         slaveSel <= slaveEn;
         lockSync <= {lockSync[0], synced};
         slaveLocked <= lockSync[1] && slaveEn;
      end
   end

   // The data pin follows whichever domain currently owns the link.
   assign serialDataOutPin = slaveSel ? sdoLink : sdoSys;

   // ----------------------------------------------------------------------
   // Domain crossings
   // ----------------------------------------------------------------------
   spaud_xfer #(.W(FW)) txXfer (
      .srcClk(sys_clk),
      .dstClk(bitClockPin),
      .rst(rst),
      .srcValid(slaveEn && txFull),
      .srcReady(xTxReady),
      .srcData(txHold),
      .dstValid(lPendValid),
      .dstData(lPendData),
      .dstTake(lrcEdge)
   );

   spaud_xfer #(.W(FW)) rxXfer (
      .srcClk(bitClockPin),
      .dstClk(sys_clk),
      .rst(rst),
      .srcValid(lRxPush),
      .srcReady(),
      .srcData(lRxWord),
      .dstValid(xRxValid),
      .dstData(xRxData),
      .dstTake(1'b1)
   );

   // ----------------------------------------------------------------------
   // Slave logic on the external bit clock
   // ----------------------------------------------------------------------
   always_ff @(posedge bitClockPin or posedge rst) begin
      if (rst) begin
         enLink <= 2'h0;
         disLink <= 2'h0;
      end else begin
         enLink <= {enLink[0], slaveEn};
         disLink <= {disLink[0], dataInDis};
      end
   end

   // The frame clock is launched by the bit clock, so it is sampled directly.
   assign lrcEdge = enLink[1] && lrcPrev && !leftRightClockIn;

   always_ff @(posedge bitClockPin or posedge rst) begin
      if (rst) begin
         lrcPrev <= 1'b0;
         synced <= 1'b0;
      end else begin
         lrcPrev <= leftRightClockIn;
         if (!enLink[1]) begin
            synced <= 1'b0;
         end else if (lrcEdge) begin
            synced <= 1'b1;
         end
      end
   end

   always_ff @(posedge bitClockPin or posedge rst) begin
      if (rst) begin
         lTxShift <= '0;
         sdoLink <= 1'b0;
      end else if (lrcEdge) begin
         lTxShift <= lPendValid ? {lPendData[FW-2:0], 1'b0} : '0;
         sdoLink <= lPendValid ? lPendData[FW-1] : 1'b0;
      end else if (synced && enLink[1]) begin
         sdoLink <= lTxShift[FW-1];
         lTxShift <= {lTxShift[FW-2:0], 1'b0};
      end else begin
         sdoLink <= 1'b0;
      end
   end

   always_ff @(posedge bitClockPin or posedge rst) begin
      if (rst) begin
         lRxShift <= '0;
         lRxPush <= 1'b0;
         lRxWord <= '0;
      end else begin
         lRxPush <= 1'b0;
         if (lrcEdge && synced && !disLink[1]) begin
            lRxWord <= lRxShift;
            lRxPush <= 1'b1;
         end
         if ((lrcEdge || synced) && enLink[1] && !disLink[1]) begin
            lRxShift <= {lRxShift[FW-2:0], serialDataInPin};
         end
      end
   end

endmodule

// File: include/spaud_pkg.sv
// Constants and types for the audio mode of the synchronous serial port.
// Assumes a 25 MHz system clock and an external bit clock in slave operation.
package spaud_pkg;

   // ----------------------------------------------------------------------
   // Control bit positions
   // ----------------------------------------------------------------------
   localparam int CTRL_H_AUDIO_EN = 15;
   localparam int CTRL_L_PORT_EN = 15;
   localparam int CTRL_L_DATA_IN_DIS = 4;
   localparam int CTRL_L_MASTER = 5;

   // ----------------------------------------------------------------------
   // Frame layout and timing
   // ----------------------------------------------------------------------
   localparam int CH_W = 16;
   localparam logic [4:0] LAST_BIT = 5'h1f;
   localparam logic [4:0] RIGHT_START = 5'h10;
   localparam int SYS_PERIOD_NS = 40;
   localparam int BCLK_HALF_NS = 160;
   localparam logic [3:0] BCLK_HALF_CYC = 4'((BCLK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [CH_W-1:0] left;
      logic [CH_W-1:0] right;
   } spaud_frame_t;

endpackage

// File: hdl/spaud_xfer.sv
// Toggle handshake that carries one word from one clock domain to another.
// Assumes the source holds nothing for it: the word is latched on acceptance.
module spaud_xfer #(
   parameter int W = 32
) (
   // Clocks and reset
   input wire logic srcClk,
   input wire logic dstClk,
   input wire logic rst,
   // Source side
   input wire logic srcValid,
   output logic srcReady,
   input wire logic [W-1:0] srcData,
   // Destination side
   output logic dstValid,
   output logic [W-1:0] dstData,
   input wire logic dstTake
);

   logic reqTog;
   logic ackTog;
   logic [W-1:0] hold;
   logic reqS1;
   logic reqS2;
   logic ackS1;
   logic ackS2;

   // ----------------------------------------------------------------------
   // Source domain
   // ----------------------------------------------------------------------
   always_ff @(posedge srcClk or posedge rst) begin
      if (rst) begin
         reqTog <= 1'b0;
         hold <= '0;
      end else if (srcValid && srcReady) begin
         reqTog <= ~reqTog;
         hold <= srcData;
      end
   end

   always_ff @(posedge srcClk or posedge rst) begin
      if (rst) begin
         ackS1 <= 1'b0;
         ackS2 <= 1'b0;
      end else begin
         ackS1 <= ackTog;
         ackS2 <= ackS1;
      end
   end

   assign srcReady = (reqTog == ackS2);

   // ----------------------------------------------------------------------
   // Destination domain
   // ----------------------------------------------------------------------
   always_ff @(posedge dstClk or posedge rst) begin
      if (rst) begin
         reqS1 <= 1'b0;
         reqS2 <= 1'b0;
      end else begin
         reqS1 <= reqTog;
         reqS2 <= reqS1;
      end
   end

   always_ff @(posedge dstClk or posedge rst) begin
      if (rst) begin
         ackTog <= 1'b0;
      end else if (dstTake && dstValid) begin
         ackTog <= ~ackTog;
      end
   end

   // The held word is stable from the toggle until the acknowledge returns.
   assign dstValid = (reqS2 != ackTog);
   assign dstData = hold;

endmodule

// File: tb/spaud_core_assertions.sv
// Checker for the audio mode of the serial port, bound to spaud_core.
// Assumes control words change off the rising edge of sys_clk.
module spaud_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Controls
   input wire logic [15:0] controlOneHigh,
   input wire logic [15:0] controlOneLow,
   input wire logic txValid,
   // Observed outputs
   input wire logic txReady,
   input wire logic rxValid,
   input wire logic slaveLocked,
   input wire logic bitClockOut,
   input wire logic bitClockOe,
   input wire logic leftRightClockOut,
   input wire logic leftRightClockOe,
   input wire logic serialDataOutPin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic aud, mEn, sEn, dis, prevBclk;
   logic [3:0] stableCnt;
   assign aud = controlOneHigh[spaud_pkg::CTRL_H_AUDIO_EN]
      && controlOneLow[spaud_pkg::CTRL_L_PORT_EN];
   assign mEn = aud && controlOneLow[spaud_pkg::CTRL_L_MASTER];
   assign sEn = aud && !controlOneLow[spaud_pkg::CTRL_L_MASTER];
   assign dis = controlOneLow[spaud_pkg::CTRL_L_DATA_IN_DIS];

   // Counts cycles since the master bit clock last changed.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prevBclk <= 1'b0;
         stableCnt <= 4'h0;
      end else begin
         prevBclk <= bitClockOut;
         if (!mEn || bitClockOut != prevBclk) begin
            stableCnt <= 4'h0;
         end else if (stableCnt != 4'hf) begin
            stableCnt <= stableCnt + 4'h1;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence masterStart;
      !mEn ##1 mEn;
   endsequence

   AST_AUDIO_OFF: assert property (!aud [*3] |-> !bitClockOe && !leftRightClockOe)
      else $error("link clock driven without audio mode");
   AST_OE_ON: assert property (masterStart |-> ##[1:2] (bitClockOe && leftRightClockOe))
      else $error("master clock enables late");
   AST_FIRST_EDGE: assert property (masterStart |-> ##[1:9] $rose(bitClockOut))
      else $error("first bit clock edge late");
   AST_BCLK_RUN: assert property (mEn && bitClockOe |-> stableCnt < 4'h7)
      else $error("master bit clock stalled");
   AST_LRC_ON_FALL: assert property (mEn && $past(mEn) && $changed(leftRightClockOut)
      |-> $fell(bitClockOut))
      else $error("frame clock moved off bit clock fall");
   AST_SLAVE_NO_DRIVE: assert property (sEn [*3] |-> !bitClockOe && !leftRightClockOe)
      else $error("slave drives link clocks");
   AST_SLAVE_QUIET: assert property (sEn && !slaveLocked && serialDataOutPin
      |-> ##[0:6] slaveLocked)
      else $error("slave output active before frame edge");
   AST_NO_RX_WHEN_DIS: assert property (dis [*8] ##1 dis [*8] ##1 dis [*8] |-> !rxValid)
      else $error("receive while data input disabled");
   AST_RX_PULSE: assert property (rxValid |=> !rxValid)
      else $error("receive strobe longer than one cycle");
   AST_TX_TAKE: assert property (txValid && txReady |=> !txReady)
      else $error("transmit holding word not marked full");
endmodule

bind spaud_core spaud_chk chk (.sys_clk(sys_clk), .rst(rst), .controlOneHigh(controlOneHigh),
   .controlOneLow(controlOneLow), .txValid(txValid), .txReady(txReady), .rxValid(rxValid),
   .slaveLocked(slaveLocked), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
   .leftRightClockOut(leftRightClockOut), .leftRightClockOe(leftRightClockOe),
   .serialDataOutPin(serialDataOutPin));

// File: tb/spaud_codec.sv
// External audio master: running bit clock, frame clock low for the left half.
// Assumes the port samples on the rising bit clock and drives after it.
module spaud_codec (
   // Control
   input wire logic run,
   input wire logic [31:0] word,
   // Link pins
   output logic bclk,
   output logic left_right_clock,
   output logic sdi,
   input wire logic sdo,
   // Last frame taken from the port
   output logic [31:0] lastWord
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = -48;
   logic [31:0] cap;

   initial begin
      {bclk, sdi, lastWord, cap} = '0;
      left_right_clock = 1'b1;
      #7;
      forever begin
         #62.5;
         if (run) bclk = ~bclk;
      end
   end

   // A preamble with no frame edge comes first; then 32-bit frames.
   always @(negedge bclk) begin
      n = (n == 31) ? 0 : n + 1;
      if (n == 0) lastWord = {cap[30:0], sdo};
      cap = {cap[30:0], sdo};
      if (n >= 0) begin
         left_right_clock = (n >= 16);
         sdi = word[31-n];
      end else begin
         sdi = ~sdi;
      end
   end
endmodule

// File: tb/spaud_core_tb_top.sv
// Testbench for the audio mode of the serial port: master then slave runs.
// Assumes the codec model stands on the link pins while the port is slave.
module spaud_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, txValid, txReady, rxValid, slaveLocked, codecRun, seenAny;
   logic [15:0] controlOneHigh, controlOneLow;
   spaud_pkg::spaud_frame_t txFrame, rxFrame;
   logic bitClockPin, bitClockOut, bitClockOe, leftRightClockIn, leftRightClockOut;
   logic leftRightClockOe, serialDataInPin, serialDataOutPin, codecBclk, codecLrc, codecSdi;
   logic [31:0] codecWord, codecLast, word;
   int num_errors = 0;
   int total_checks = 0;

   spaud_core dut (.sys_clk(sys_clk), .rst(rst), .controlOneHigh(controlOneHigh),
      .controlOneLow(controlOneLow), .txFrame(txFrame), .txValid(txValid), .txReady(txReady),
      .rxFrame(rxFrame), .rxValid(rxValid), .slaveLocked(slaveLocked),
      .bitClockPin(bitClockPin), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
      .leftRightClockIn(leftRightClockIn), .leftRightClockOut(leftRightClockOut),
      .leftRightClockOe(leftRightClockOe), .serialDataInPin(serialDataInPin),
      .serialDataOutPin(serialDataOutPin));
   spaud_codec codec (.run(codecRun), .word(codecWord), .bclk(codecBclk), .left_right_clock(codecLrc),
      .sdi(codecSdi), .sdo(serialDataOutPin), .lastWord(codecLast));
   assign bitClockPin = bitClockOe ? bitClockOut : codecBclk;
   assign leftRightClockIn = leftRightClockOe ? leftRightClockOut : codecLrc;
   assign serialDataInPin = bitClockOe ? serialDataOutPin : codecSdi;

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_lvl(ref logic sig, input logic val, input int lim);
      for (int i = 0; i < lim && sig !== val; i++) @(negedge sys_clk);
      if (sig !== val) begin
         num_errors++;
         report_and_stop;
      end
   endtask

   task automatic set_mode(input logic aud, input logic en, input logic mst, input logic dis);
      @(negedge sys_clk);
      controlOneHigh[spaud_pkg::CTRL_H_AUDIO_EN] = aud;
      controlOneLow[spaud_pkg::CTRL_L_PORT_EN] = en;
      controlOneLow[spaud_pkg::CTRL_L_MASTER] = mst;
      controlOneLow[spaud_pkg::CTRL_L_DATA_IN_DIS] = dis;
   endtask

   task automatic send(input logic [31:0] v);
      wait_lvl(txReady, 1'b1, 600);
      txFrame = v;
      txValid = 1'b1;
      @(negedge sys_clk);
      txValid = 1'b0;
   endtask

   // Collects one master frame, sampling data while the bit clock is high.
   task automatic grab(output logic [31:0] w);
      w = 32'h0;
      wait_lvl(leftRightClockOut, 1'b1, 600);
      wait_lvl(leftRightClockOut, 1'b0, 600);
      for (int i = 0; i < 32; i++) begin
         wait_lvl(bitClockOut, 1'b1, 20);
         w = {w[30:0], serialDataOutPin};
         wait_lvl(bitClockOut, 1'b0, 20);
      end
   endtask

   task automatic next_frame;
      wait_lvl(rxValid, 1'b1, 300);
      @(negedge sys_clk);
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      {controlOneHigh, controlOneLow, txFrame, txValid, codecRun} = '0;
      codecWord = 32'h3c5a96f0;
      rst = 1'b1;
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      check({30'h0, leftRightClockOut, bitClockOe}, 32'h2);
      set_mode(1'b0, 1'b1, 1'b1, 1'b0);
      repeat (20) @(negedge sys_clk);
      check({31'h0, bitClockOe}, 32'h0);
      set_mode(1'b1, 1'b1, 1'b1, 1'b0);
      repeat (3) @(negedge sys_clk);
      check({30'h0, bitClockOe, leftRightClockOe}, 32'h3);
      grab(word);
      check(word, 32'h0);
      send(32'ha5c31e69);
      for (int i = 0; i < 3 && word !== 32'ha5c31e69; i++) grab(word);
      check(word, 32'ha5c31e69);
      check(rxFrame, 32'ha5c31e69);
      grab(word);
      check(word, 32'h0);
      set_mode(1'b1, 1'b0, 1'b1, 1'b0);
      repeat (4) @(negedge sys_clk);
      check({30'h0, leftRightClockOut, bitClockOe}, 32'h2);
      set_mode(1'b1, 1'b1, 1'b0, 1'b0);
      codecRun = 1'b1;
      send(32'hc3a50f96);
      seenAny = 1'b0;
      repeat (100) begin
         @(negedge sys_clk);
         seenAny = seenAny | serialDataOutPin;
      end
      check({31'h0, seenAny}, 32'h0);
      wait_lvl(rxValid, 1'b1, 3000);
      check(rxFrame, codecWord);
      check({31'h0, slaveLocked}, 32'h1);
      for (int i = 0; i < 4 && codecLast !== 32'hc3a50f96; i++) next_frame();
      check(codecLast, 32'hc3a50f96);
      next_frame();
      next_frame();
      check(codecLast, 32'h0);
      set_mode(1'b1, 1'b1, 1'b0, 1'b1);
      repeat (20) @(negedge sys_clk);
      seenAny = 1'b0;
      repeat (300) begin
         @(negedge sys_clk);
         seenAny = seenAny | rxValid;
      end
      check({31'h0, seenAny}, 32'h0);
      report_and_stop;
   end
endmodule
